/* bench/bmam_map_bench.sv */
// Purpose: Self-checking bench for the address map
// Assumes: Avalon master tasks, one access at a time
// Notes: Expected data come from the map ranges
`timescale 1ns/1ps
`default_nettype none
module bmam_map_bench;
  logic clk_sys, rst_n, avsRead, avsWrite, avsWaitRequest;
  logic [3:0] avsAddress, avsByteEnable;
  logic [31:0] avsWriteData, avsReadData, q;
  logic [11:0] progAddr;
  logic [13:0] progWord;
  integer fail_count = 0, check_count = 0, cycles = 0, seed = 32'h7a5bbddb;
  integer i, b, o, v, a, x;
  bmam_map uut (.clk_sys, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .progAddr, .progWord);
  bmam_prog_model far (.progAddr, .progWord);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the expected run
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end
  // Implemented RAM windows
  function automatic bit inRam(input integer n);
    inRam = (n >= 32 && n < 128) || (n >= 160 && n < 240) || (n >= 288 && n < 368)
      || (n >= 416 && n < 496);
  endfunction
  // One bus cycle; holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_sys);
    avsAddress <= ad;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    do begin
      @(posedge clk_sys);
      n = n + 1;
    end while (avsWaitRequest !== 1'b0 && n < 40);
    q = avsReadData;
    if (n >= 40) fail_count = fail_count + 1;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
    avsByteEnable = 4'h3;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(0, 4'h0, 0);
    cmp(q, 32'h18);
    cmp(progAddr, 0);
    for (i = 0; i < 8; i++) begin
      v = $random(seed) & 32'h1FFF;
      bus(1, 4'h4, v);
      cmp(progAddr, v[11:0]);
      bus(0, 4'hC, 0);
      cmp(q[13:0], {v[11:0], 2'b01} ^ 14'h2A5C);
    end
    bus(1, 4'h4, 32'h4000);
    cmp(progAddr, 12'h004);
    bus(1, 4'h4, 32'h2000);
    cmp(progAddr, 12'h005);
    bus(0, 4'h6, 0);
    cmp(q, 0);
    $display("program side done");
    bus(1, 4'h0, 32'h5AFF);
    bus(0, 4'h0, 0);
    cmp(q[15:0], 16'h5AF8);
    // Random bank and offset, read direct then indirect
    for (i = 0; i < 24; i++) begin
      b = $random(seed) & 3;
      o = 32 + ((($random(seed)) & 32'hFFFF) % 96);
      v = $random(seed) & 255;
      a = b * 128 + o;
      x = inRam(a) ? v : 0;
      bus(1, 4'h0, {16'h0, b[0], o[6:0], b[1], b[1:0], 5'h0});
      bus(1, 4'h8, {13'h0, v[7:0], 2'b10, b[1:0], o[6:0]});
      bus(0, 4'h8, {21'h0, 2'b00, b[1:0], o[6:0]});
      cmp(q[7:0], x[7:0]);
      bus(0, 4'h8, 32'h200);
      cmp(q[7:0], x[7:0]);
    end
    $display("data map done");
    bus(1, 4'h0, 32'h40);
    bus(1, 4'h8, {13'h0, 8'hC3, 2'b10, 9'h150});
    bus(1, 4'h8, {3'h0, 1'b1, 9'h0A5, 8'h0, 2'b00, 9'h150});
    bus(1, 4'h0, 32'h20);
    bus(0, 4'h8, {21'h0, 2'b00, 9'h0A5});
    cmp(q[7:0], 8'hC3);
    bus(1, 4'h8, {13'h0, 8'h77, 2'b10, 9'h004});
    bus(0, 4'h0, 0);
    cmp(q, 32'h7738);
    bus(0, 4'h8, 32'h003);
    cmp(q[7:0], 8'h38);
    bus(0, 4'h8, 32'h000);
    cmp(q[7:0], 8'h00);
    $display("move done");
    give_verdict();
  end
endmodule // bmam_map_bench
`default_nettype wire

/* bench/bmam_map_props.sv */
// Purpose: Bus timing and program port checks
// Assumes: Bound to bmam_map
// Notes: Answers are judged where waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module bmam_map_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  // Program port
  input wire logic [11:0] progAddr,
  input wire logic [13:0] progWord
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A new request, and a program counter write being answered
  sequence reqStart; $rose(avsRead || avsWrite); endsequence
  sequence pcWr; !avsWaitRequest && avsWrite && avsAddress == 4'h4; endsequence
  a_answer_one_cycle: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
  a_fast_answer: assert property ((reqStart ##0 avsAddress != 4'h8) |=> !avsWaitRequest)
    else $error("late answer");
  a_data_answer: assert property ((reqStart ##0 avsAddress == 4'h8 && !avsWriteData[28])
    |=> avsWaitRequest ##1 !avsWaitRequest) else $error("data answer timing");
  a_pc_only_write: assert property ($changed(progAddr) |-> pcWr)
    else $error("program address moved alone");
  a_irq_vector: assert property ((pcWr ##0 avsWriteData[14:13] == 2'b10) |-> progAddr == 12'h004)
    else $error("bad interrupt vector");
  a_load_wrap: assert property ((pcWr ##0 avsWriteData[14:13] == 2'b00)
    |-> progAddr == avsWriteData[11:0]) else $error("bad wrap");
  a_unmapped_zero: assert property (!avsWaitRequest && avsRead && avsAddress[1:0] != 2'b00
    |-> avsReadData == 32'h00000000) else $error("unmapped read not zero");
  a_prog_word: assert property (!avsWaitRequest && avsRead && avsAddress == 4'hC
    |-> avsReadData[13:0] == progWord) else $error("bad program word");
endmodule // bmam_map_props
bind bmam_map bmam_map_props chk (.clk_sys, .rst_n, .avsAddress, .avsRead, .avsWrite,
  .avsWriteData, .avsReadData, .avsWaitRequest, .progAddr, .progWord);
`default_nettype wire

/* bench/bmam_prog_model.sv */
// Purpose: Program array standing at the far side
// Assumes: Combinational read of the addressed word
// Notes: Scrambled contents make a wrong address visible
`timescale 1ns/1ps
`default_nettype none
module bmam_prog_model (
  // Program port
  input wire logic [11:0] progAddr,
  output logic [13:0] progWord
);
  // One whole word per address, no second fetch
  assign progWord = {progAddr, 2'b01} ^ 14'h2A5C;
endmodule // bmam_prog_model
`default_nettype wire

/* pkg/bmam_defines.vh */
// Purpose: Constants for the banked memory address map block.
// Assumes: Included by bare name from the design files.
// Notes: Avalon register offsets are byte addresses on the Avalon-MM register bus.
`ifndef BMAM_DEFINES_VH
`define BMAM_DEFINES_VH
// Program side
`define BMAM_PC_W 13
`define BMAM_PMEM_AW 12
`define BMAM_INSN_W 14
`define BMAM_RESET_VEC 13'h0000
`define BMAM_IRQ_VEC 13'h0004
// Data side
`define BMAM_DADDR_W 9
`define BMAM_SPECIAL_TOP 7'h1F
`define BMAM_RAM_LO0 9'h020
`define BMAM_RAM_HI0 9'h07F
`define BMAM_RAM_LO1 9'h0A0
`define BMAM_RAM_HI1 9'h0EF
`define BMAM_RAM_LO2 9'h120
`define BMAM_RAM_HI2 9'h16F
`define BMAM_RAM_LO3 9'h1A0
`define BMAM_RAM_HI3 9'h1EF
// Core register offsets within a bank
`define BMAM_CORE_IND_PORT 7'h00
`define BMAM_CORE_PC_LOW 7'h02
`define BMAM_CORE_STATUS 7'h03
`define BMAM_CORE_PTR 7'h04
`define BMAM_CORE_PC_LATCH 7'h0A
`define BMAM_CORE_INTCTL 7'h0B
// Status field positions
`define BMAM_ST_IND_BANK 7
`define BMAM_ST_BANK_HI 6
`define BMAM_ST_BANK_LO 5
`define BMAM_STATUS_RST 8'h18
// Avalon register offsets
`define BMAM_REG_CTRL 4'h0
`define BMAM_REG_PC 4'h4
`define BMAM_REG_DATA 4'h8
`define BMAM_REG_PROG 4'hC
`define BMAM_RAM_AW 9
`endif

/* verilog/bmam_map.v */
// Purpose: Program and data memory address map with Avalon-MM access.
// Assumes: Core talks through the register bus; program array is external.
// Notes: One access at a time; waitrequest falls for one cycle.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "bmam_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module bmam_map (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Avalon-MM slave
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  // Program memory port
  output reg [11:0] progAddr,
  input wire [13:0] progWord
);
  // Control fields written by software
  // Bus writes and core-register writes share these flops, so the
  // two paths can never disagree about the bank selection
  reg [7:0] statusReg, statusNext; // Bank bits live here
  reg [7:0] pointerReg, pointerNext; // Indirect pointer
  reg [4:0] pcLatchReg, pcLatchNext; // Upper program counter latch
  reg [7:0] intctlReg, intctlNext; // Interrupt control byte
  reg [12:0] pcReg, pcNext; // Program counter
  // Fetched word is held in a flop so program reads answer from a register
  reg [13:0] insnReg; // Last fetched word
  reg [7:0] workReg; // Working register for moves
  // Access state machine, one-hot
  // DONE always precedes IDLE, which gives the master one quiet cycle
  // and keeps waitrequest low for exactly one edge
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_MOVE = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  reg [3:0] stateReg, stateNext;
  // Decoded access
  reg isDataWr;
  reg [8:0] fullAddr;
  reg [6:0] fileOfs;
  reg isRam; // Location is implemented RAM
  reg isCore; // Location is a special register
  reg isDestRam; // Move destination is implemented RAM
  reg [7:0] coreRd;
  wire [7:0] ramRd;
  reg ramWe;
  reg [8:0] ramAddr;
  reg [7:0] ramWd;
  reg [31:0] rdNext;
  // Data command layout in the data register write:
  // [6:0] file address, [9] indirect, [10] write, [18:11] write byte,
  // [27:19] move destination, [28] move request.
  wire cmdInd = avsWriteData[9];
  wire cmdWr = avsWriteData[10];
  wire cmdMove = avsWriteData[28];
  // Latched command for multi-cycle data access
  // Held so the master may keep or change its bus signals after the
  // taking edge without disturbing the access in flight
  reg [8:0] latAddr;
  reg latWr, latMove;
  reg [7:0] latData;
  reg [8:0] latDest;

  // Address formation for direct and indirect paths
  // Direct: two bank bits over the seven-bit file address
  // Indirect: the indirect bank bit over the whole pointer
  always @* begin
    fullAddr = {statusReg[`BMAM_ST_BANK_HI], statusReg[`BMAM_ST_BANK_LO],
                avsWriteData[6:0]};
    if (cmdInd) begin
      fullAddr = {statusReg[`BMAM_ST_IND_BANK], pointerReg};
    end
  end

  // Region decode of the latched address
  // Only the offset within the bank picks a special register, so the
  // core set shows up at the same place in every bank
  always @* begin
    fileOfs = latAddr[6:0];
    isCore = (fileOfs <= `BMAM_SPECIAL_TOP);
    // Four RAM windows, each bounded at both ends
    isRam = ((latAddr >= `BMAM_RAM_LO0) && (latAddr <= `BMAM_RAM_HI0)) ||
            ((latAddr >= `BMAM_RAM_LO1) && (latAddr <= `BMAM_RAM_HI1)) ||
            ((latAddr >= `BMAM_RAM_LO2) && (latAddr <= `BMAM_RAM_HI2)) ||
            ((latAddr >= `BMAM_RAM_LO3) && (latAddr <= `BMAM_RAM_HI3));
    // Core register readback; the indirect port itself reads as zero
    // since reading through it would need a second lookup
    case (fileOfs)
      `BMAM_CORE_PC_LOW: coreRd = pcReg[7:0];
      `BMAM_CORE_STATUS: coreRd = statusReg;
      `BMAM_CORE_PTR: coreRd = pointerReg;
      `BMAM_CORE_PC_LATCH: coreRd = {3'h0, pcLatchReg};
      `BMAM_CORE_INTCTL: coreRd = intctlReg;
      // Peripheral slots and holes in the map
      default: coreRd = 8'h00;
    endcase
  end

  // Destination check for moves
  // A move into a hole or a special slot is dropped, not stored
  always @* begin
    isDestRam = ((latDest >= `BMAM_RAM_LO0) && (latDest <= `BMAM_RAM_HI0)) ||
                ((latDest >= `BMAM_RAM_LO1) && (latDest <= `BMAM_RAM_HI1)) ||
                ((latDest >= `BMAM_RAM_LO2) && (latDest <= `BMAM_RAM_HI2)) ||
                ((latDest >= `BMAM_RAM_LO3) && (latDest <= `BMAM_RAM_HI3));
  end

  // RAM drive: store on write of an implemented location
  // The read address is presented while the request is taken, so the
  // registered read data are already valid in the wait cycle
  always @* begin
    ramAddr = latAddr;
    ramWd = latData;
    ramWe = 1'b0;
    isDataWr = 1'b0;
    if (stateReg == ST_IDLE) begin
      // Look ahead at the address being taken at this edge
      ramAddr = fullAddr;
    end else if (stateReg == ST_WAIT) begin
      // Plain writes only; a move stores later from the working register
      isDataWr = latWr && !latMove;
      ramWe = isDataWr && isRam;
    end else if (stateReg == ST_MOVE) begin
      // Second cycle of a move: working register into the destination
      ramAddr = latDest;
      ramWd = workReg;
      ramWe = isDestRam;
    end
  end

  // RAM storage module
  // Whole nine-bit space is backed; the decode above keeps the holes
  // reading as zero, trading unused cells for a simpler address path
  bmam_ram uRam (
    .clk_sys(clk_sys),
    .wrEn(ramWe),
    .addr(ramAddr),
    .wrData(ramWd),
    .rdData(ramRd)
  );

  // Bus and core register next-state logic
  // Requests are taken only in IDLE; anything that arrives while an
  // access is in flight waits, since waitrequest is still high
  always @* begin
    stateNext = stateReg;
    statusNext = statusReg;
    pointerNext = pointerReg;
    // Hold everything unless a branch below says otherwise
    pcLatchNext = pcLatchReg;
    intctlNext = intctlReg;
    pcNext = pcReg;
    rdNext = avsReadData;
    case (stateReg)
      ST_IDLE: begin
        if (avsWrite) begin
          case (avsAddress)
            `BMAM_REG_CTRL: begin
              if (avsByteEnable[0]) begin
                statusNext = {avsWriteData[7:5], statusReg[4:0]};
              end
              if (avsByteEnable[1]) begin
                pointerNext = avsWriteData[15:8];
              end
              if (avsByteEnable[2]) begin
                // Upper program counter latch, five bits
                pcLatchNext = avsWriteData[20:16];
              end
              if (avsByteEnable[3]) begin
                intctlNext = avsWriteData[31:24];
              end
            end
            `BMAM_REG_PC: begin
              if (avsWriteData[14]) begin
                pcNext = `BMAM_IRQ_VEC;
              end else if (avsWriteData[13]) begin
                pcNext = pcReg + 13'h0001;
              end else begin
                pcNext = avsWriteData[12:0];
              end
              stateNext = ST_DONE;
            end
            `BMAM_REG_DATA: stateNext = ST_WAIT;
            default: stateNext = ST_DONE;
          endcase
          if (avsAddress != `BMAM_REG_PC && avsAddress != `BMAM_REG_DATA) begin
            stateNext = ST_DONE;
          end
        end else if (avsRead) begin
          case (avsAddress)
            // Control word packs all four core bytes
            `BMAM_REG_CTRL: rdNext = {intctlReg, 3'h0, pcLatchReg, pointerReg,
                                       statusReg};
            `BMAM_REG_PC: rdNext = {19'h00000, pcReg};
            // Word fetched last cycle; the program address has not moved
            `BMAM_REG_PROG: rdNext = {18'h00000, insnReg};
            default: rdNext = 32'h00000000;
          endcase
          stateNext = ST_DONE;
          if (avsAddress == `BMAM_REG_DATA) begin
            stateNext = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Registered RAM data valid now
        if (isCore && latWr) begin
          case (fileOfs)
            `BMAM_CORE_STATUS: statusNext = {latData[7:5], statusReg[4:0]};
            `BMAM_CORE_PTR: pointerNext = latData;
            `BMAM_CORE_PC_LATCH: pcLatchNext = latData[4:0];
            `BMAM_CORE_INTCTL: intctlNext = latData;
            // Low byte write jumps, with the latch supplying the top bits
            `BMAM_CORE_PC_LOW: pcNext = {pcLatchReg, latData};
            default: pcNext = pcReg;
          endcase
        end
        // Readback byte: special register, RAM, or zero for a hole
        rdNext = {24'h000000, isCore ? coreRd : (isRam ? ramRd : 8'h00)};
        stateNext = latMove ? ST_MOVE : ST_DONE;
      end
      ST_MOVE: stateNext = ST_DONE;
      ST_DONE: stateNext = ST_IDLE;
      default: stateNext = ST_IDLE;
    endcase
  end

  // Registered state, reset to vectors and defaults
  // Waitrequest is high through reset, so a request that is already
  // standing at release is simply taken at the first edge in IDLE
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ST_IDLE;
      statusReg <= `BMAM_STATUS_RST;
      pointerReg <= 8'h00;
      pcLatchReg <= 5'h00;
      intctlReg <= 8'h00;
      pcReg <= `BMAM_RESET_VEC;
      avsReadData <= 32'h00000000;
      avsWaitRequest <= 1'b1;
      progAddr <= 12'h000;
      insnReg <= 14'h0000;
      latAddr <= 9'h000;
      latWr <= 1'b0;
      latMove <= 1'b0;
      latData <= 8'h00;
      latDest <= 9'h000;
      workReg <= 8'h00;
    end else begin
      stateReg <= stateNext;
      statusReg <= statusNext;
      pointerReg <= pointerNext;
      // Core bytes follow their next values every cycle
      pcLatchReg <= pcLatchNext;
      intctlReg <= intctlNext;
      pcReg <= pcNext;
      avsReadData <= rdNext;
      avsWaitRequest <= !(stateNext == ST_DONE);
      progAddr <= pcNext[11:0];
      insnReg <= progWord;
      if (stateReg == ST_IDLE && avsAddress == `BMAM_REG_DATA) begin
        latAddr <= fullAddr;
        latWr <= avsWrite && cmdWr;
        latMove <= avsWrite && cmdMove;
        latData <= avsWriteData[18:11];
        latDest <= avsWriteData[27:19];
      end
      // First cycle of every data access loads the working register
      if (stateReg == ST_WAIT) begin
        workReg <= isCore ? coreRd : (isRam ? ramRd : 8'h00);
      end
    end
  end
endmodule // bmam_map
`default_nettype wire

/* verilog/bmam_ram.v */
// Purpose: General-purpose RAM storage for the data map.
// Assumes: One clock, write and registered read share one address.
// Notes: Read data come out of a register, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module bmam_ram (
  // Clock
  input wire clk_sys,
  // Access
  input wire wrEn,
  input wire [8:0] addr,
  input wire [7:0] wrData,
  output reg [7:0] rdData
);
  // Storage array, contents undefined at power-up as for static RAM
  reg [7:0] mem [0:511];
  // Registered read, read first
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule // bmam_ram
`default_nettype wire
